// >>> rtl/cantx_defs.vh
`ifndef CANTX_DEFS_VH
`define CANTX_DEFS_VH
// Register offsets on the plain register port.
`define CANTX_OFS_RIER   4'h0
`define CANTX_OFS_TFLG   4'h1
`define CANTX_OFS_TCR    4'h2
`define CANTX_OFS_IDAC   4'h3
`define CANTX_OFS_RXERR  4'h4
`define CANTX_OFS_TXERR  4'h5
`define CANTX_OFS_MCR0   4'h6
`define CANTX_OFS_CODE0  4'h8
`define CANTX_OFS_MASK0  4'hC
// Field positions.
`define CANTX_RXFULL_IE_BIT 0
`define CANTX_SOFT_RST_BIT  0
`define CANTX_ABORT_LSB     4
`define CANTX_MODE_LSB      4
// Reset values.
`define CANTX_RST_RIER   8'h00
`define CANTX_RST_TFLG   8'h07
`define CANTX_RST_TCR    8'h00
`define CANTX_RST_MODE   2'h0
`define CANTX_RST_ACC    8'h00
`define CANTX_RST_MCR0   8'h01
// Acceptance modes.
`define CANTX_MODE_32    2'h0
`define CANTX_MODE_16    2'h1
`define CANTX_MODE_8     2'h2
`define CANTX_MODE_SHUT  2'h3
`endif

// >>> rtl/cantx_filter.v
`include "cantx_defs.vh"

// Acceptance filter: purely combinational, compares identifier bytes to code
// under mask and reports acceptance plus the number of the hitting filter.
module cantx_filter (
  input  wire [31:0] code,
  input  wire [31:0] mask,
  input  wire [1:0]  mode,
  input  wire [31:0] ident,
  input  wire        ext_id,
  output reg         accept,
  output reg  [1:0]  hit
);
  wire [31:0] bit_ok;
  reg  [3:0]  fok;

  // A set mask bit makes its bit don't-care; a clear one needs equality.
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      assign bit_ok[i] = mask[i] | (code[i] == ident[i]);
    end
  endgenerate

  // Byte 0 sits in bits 31:24, byte 3 in bits 7:0.
  always @* begin
    fok = 4'h0;
    accept = 1'b0;
    hit = 2'h0;
    case (mode)
      `CANTX_MODE_32: begin
        // Standard identifiers only use the first two bytes.
        fok[0] = ext_id ? &bit_ok : &bit_ok[31:16];
      end
      `CANTX_MODE_16: begin
        fok[0] = &bit_ok[31:16];
        fok[1] = &bit_ok[15:0];
      end
      `CANTX_MODE_8: begin
        fok[0] = &bit_ok[31:24];
        fok[1] = &bit_ok[23:16];
        fok[2] = &bit_ok[15:8];
        fok[3] = &bit_ok[7:0];
      end
      default: fok = 4'h0;
    endcase
    accept = |fok;
    // Lowest numbered filter wins when several hit.
    if (fok[0]) begin
      hit = 2'h0;
    end else if (fok[1]) begin
      hit = 2'h1;
    end else if (fok[2]) begin
      hit = 2'h2;
    end else if (fok[3]) begin
      hit = 2'h3;
    end
  end
endmodule

// >>> rtl/cantx_slot.v
`include "cantx_defs.vh"

// One transmit buffer's handshake: empty flag, abort request and ack.
module cantx_slot (
  input  wire clk,
  input  wire rst_n,
  input  wire hold,
  input  wire clr_empty,
  input  wire set_abort_rq,
  input  wire sent,
  input  wire abort_ok,
  input  wire irq_en,
  output reg  empty,
  output reg  abort_ack,
  output reg  abort_rq,
  output wire irq
);
  wire set_empty;
  wire grant;

  // An abort is granted only while a request is pending and slot is busy.
  assign grant = abort_rq & abort_ok & ~empty;
  assign set_empty = ~empty & (sent | grant);
  assign irq = empty & irq_en;

  // Soft reset holds the whole slot in reset; setting beats a clear write.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      empty <= 1'b1;
      abort_ack <= 1'b0;
      abort_rq <= 1'b0;
    end else if (hold) begin
      empty <= 1'b1;
      abort_ack <= 1'b0;
      abort_rq <= 1'b0;
    end else begin
      if (set_empty) begin
        empty <= 1'b1;
        abort_ack <= grant & ~sent;
        abort_rq <= 1'b0;
      end else begin
        if (clr_empty & empty) begin
          empty <= 1'b0;
          abort_ack <= 1'b0;
        end
        if (set_abort_rq & ~empty) begin
          abort_rq <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> rtl/cantx_top.v
// Functional notes
// - Receive-full enable set lets an accepted reception raise receive irq.
// - Soft reset holds interrupt enable, transmit flags, transmit control.
// - Empty flags clear on written one; ack flags read-only; resets clear.
// - Per-buffer abort ack: 1 aborted, 0 sent; clears with empty.
// - CPU clears empty to schedule; device sets it after successful send.
// - Successful abort sets empty; interrupt pending unless masked.
// - Empty flag becoming set clears its abort request bit.
// - Abort granted before start or after failed attempt; sets empty, ack.
// - Writing 0 never clears abort request; only device, soft reset or reset clears it.
// - Per-buffer empty interrupt enables gate transmit interrupt.
// - Mode field: one 32, two 16, four 8-bit filters, or closed.
// - Closed mode accepts nothing; foreground buffer never reloaded.
// - Hit indicator names matching filter, updated on foreground copy.
// - Mode, code and mask registers writable only under soft reset.
// - Error counters read-only; software reads them in sleep or reset.
// - All receptions land in background; only accepted ones signal CPU.
// - Filter covers four identifier bytes; standard uses first two.
// - Mask 1 means don't-care, 0 requires equality; all must match.
`include "cantx_defs.vh"

module cantx_top (
  input  wire        CLK,
  input  wire        RSTN,
  input  wire [3:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  input  wire        RX_DONE,
  input  wire [31:0] RX_IDENT,
  input  wire        RX_EXT,
  input  wire        RX_FULL_CLR,
  input  wire [2:0]  TX_SENT,
  input  wire [2:0]  TX_ABORT_OK,
  input  wire [7:0]  RX_ERR_CNT,
  input  wire [7:0]  TX_ERR_CNT,
  input  wire        SLEEP,
  output wire        SOFT_RESET,
  output wire [2:0]  TX_EMPTY,
  output wire [2:0]  TX_ABORT_REQ,
  output reg         RX_LOAD,
  output wire [1:0]  FILTER_HIT,
  output wire        RX_IRQ,
  output wire        TX_IRQ
);
  reg  [1:0]  rst_sync;
  wire        rst_n;
  reg  [7:0]  mcr0;
  reg  [7:0]  rier;
  reg  [2:0]  tx_ie;
  reg  [1:0]  acc_mode;
  reg  [1:0]  hit;
  reg  [7:0]  code [0:3];
  reg  [7:0]  mask [0:3];
  reg         rx_full;
  wire        hold;
  wire        f_accept;
  wire [1:0]  f_hit;
  wire [2:0]  empty;
  wire [2:0]  ack;
  wire [2:0]  abort_rq;
  wire [2:0]  slot_irq;
  wire        wr_tflg;
  wire        wr_tcr;
  wire        cfg_ok;
  wire        err_ok;
  reg  [7:0]  next_rdata;
  integer     k;

  // Reset is released through two flops so all flops leave reset together.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Soft reset state and register write qualifiers.
  assign hold = mcr0[`CANTX_SOFT_RST_BIT];
  assign SOFT_RESET = hold;
  assign wr_tflg = WR & (ADDR == `CANTX_OFS_TFLG);
  assign wr_tcr = WR & (ADDR == `CANTX_OFS_TCR) & ~hold;
  assign cfg_ok = WR & hold;
  // Counters are only meaningful to software while the engine is parked.
  assign err_ok = SLEEP | hold;

  // Module control: only the soft reset bit is kept here.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mcr0 <= `CANTX_RST_MCR0;
    end else if (WR && ADDR == `CANTX_OFS_MCR0) begin
      mcr0 <= {7'h00, WDATA[`CANTX_SOFT_RST_BIT]};
    end
  end

  // Interrupt enables and transmit control are held at their reset values under soft reset.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rier <= `CANTX_RST_RIER;
      tx_ie <= 3'h0;
    end else if (hold) begin
      rier <= `CANTX_RST_RIER;
      tx_ie <= 3'h0;
    end else begin
      if (WR && ADDR == `CANTX_OFS_RIER) begin
        rier <= WDATA;
      end
      if (wr_tcr) begin
        tx_ie <= WDATA[2:0];
      end
    end
  end

  // Acceptance configuration writes pass only under soft reset.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_mode <= `CANTX_RST_MODE;
      for (k = 0; k < 4; k = k + 1) begin
        code[k] <= `CANTX_RST_ACC;
        mask[k] <= `CANTX_RST_ACC;
      end
    end else if (cfg_ok) begin
      if (ADDR == `CANTX_OFS_IDAC) begin
        acc_mode <= WDATA[`CANTX_MODE_LSB+1:`CANTX_MODE_LSB];
      end
      for (k = 0; k < 4; k = k + 1) begin
        if (ADDR == `CANTX_OFS_CODE0 + k[3:0]) begin
          code[k] <= WDATA;
        end
        if (ADDR == `CANTX_OFS_MASK0 + k[3:0]) begin
          mask[k] <= WDATA;
        end
      end
    end
  end

  cantx_filter u_filter (
    .code   ({code[0], code[1], code[2], code[3]}),
    .mask   ({mask[0], mask[1], mask[2], mask[3]}),
    .mode   (acc_mode),
    .ident  (RX_IDENT),
    .ext_id (RX_EXT),
    .accept (f_accept),
    .hit    (f_hit)
  );

  // A reception that passes the filter is copied to the foreground only
  // while the foreground is free; rejected ones stay in the background.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_full <= 1'b0;
      hit <= 2'h0;
      RX_LOAD <= 1'b0;
    end else if (hold) begin
      rx_full <= 1'b0;
      RX_LOAD <= 1'b0;
    end else begin
      RX_LOAD <= 1'b0;
      if (RX_DONE && f_accept && !rx_full) begin
        rx_full <= 1'b1;
        hit <= f_hit;
        RX_LOAD <= 1'b1;
      end else if (RX_FULL_CLR) begin
        rx_full <= 1'b0;
      end
    end
  end
  assign FILTER_HIT = hit;
  assign RX_IRQ = rx_full & rier[`CANTX_RXFULL_IE_BIT];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_slot
      cantx_slot u_slot (
        .clk          (CLK),
        .rst_n        (rst_n),
        .hold         (hold),
        .clr_empty    (wr_tflg & WDATA[g]),
        .set_abort_rq (wr_tcr & WDATA[`CANTX_ABORT_LSB+g]),
        .sent         (TX_SENT[g]),
        .abort_ok     (TX_ABORT_OK[g]),
        .irq_en       (tx_ie[g]),
        .empty        (empty[g]),
        .abort_ack    (ack[g]),
        .abort_rq     (abort_rq[g]),
        .irq          (slot_irq[g])
      );
    end
  endgenerate
  assign TX_EMPTY = empty;
  assign TX_ABORT_REQ = abort_rq;
  assign TX_IRQ = |slot_irq;

  // Read mux; error counters read back only in sleep or soft reset.
  always @* begin
    next_rdata = 8'h00;
    case (ADDR)
      `CANTX_OFS_RIER: next_rdata = rier;
      `CANTX_OFS_TFLG: next_rdata = {1'b0, ack, 1'b0, empty};
      `CANTX_OFS_TCR: next_rdata = {1'b0, abort_rq, 1'b0, tx_ie};
      `CANTX_OFS_IDAC: next_rdata = {2'h0, acc_mode, 2'h0, hit};
      `CANTX_OFS_RXERR: next_rdata = err_ok ? RX_ERR_CNT : 8'h00;
      `CANTX_OFS_TXERR: next_rdata = err_ok ? TX_ERR_CNT : 8'h00;
      `CANTX_OFS_MCR0: next_rdata = mcr0;
      4'h8, 4'h9, 4'hA, 4'hB: next_rdata = code[ADDR[1:0]];
      4'hC, 4'hD, 4'hE, 4'hF: next_rdata = mask[ADDR[1:0]];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

// >>> bench/cantx_chk.sv
module cantx_chk (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic [3:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       RX_DONE,
  input wire logic [2:0] TX_SENT,
  input wire logic [2:0] TX_ABORT_OK,
  input wire logic       SLEEP,
  input wire logic       SOFT_RESET,
  input wire logic [2:0] TX_EMPTY,
  input wire logic [2:0] TX_ABORT_REQ,
  input wire logic       RX_LOAD,
  input wire logic       RX_IRQ,
  input wire logic       TX_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Two samples of soft reset let the held registers settle first.
  chk_soft_hold: assert property (SOFT_RESET [*2] |->
    TX_EMPTY == 3'h7 && TX_ABORT_REQ == 3'h0 && !TX_IRQ && !RX_IRQ)
    else $error("soft reset did not hold the flags");
  chk_sent_sets: assert property (TX_SENT[1] && !TX_EMPTY[1]
    |=> TX_EMPTY[1])
    else $error("send did not set the empty flag");
  chk_rq_clears: assert property ($rose(TX_EMPTY[2])
    |-> !TX_ABORT_REQ[2])
    else $error("abort request kept after empty");
  chk_abort_grant: assert property (TX_ABORT_REQ[2] && TX_ABORT_OK[2]
    |=> TX_EMPTY[2] && !TX_ABORT_REQ[2])
    else $error("abort not granted");
  chk_rq_kept: assert property (TX_ABORT_REQ[2] && !TX_ABORT_OK[2] &&
    !TX_SENT[2] && !SOFT_RESET && !(WR && ADDR == 4'h6)
    |=> TX_ABORT_REQ[2])
    else $error("abort request lost");
  chk_txirq_none: assert property (TX_EMPTY == 3'h0 |-> !TX_IRQ)
    else $error("transmit irq without empty flag");
  chk_err_gate: assert property (RD && ADDR == 4'h4 && !SLEEP &&
    !SOFT_RESET |=> RDATA == 8'h00)
    else $error("error count visible while running");
  chk_load_cause: assert property (RX_LOAD |-> $past(RX_DONE))
    else $error("load without reception");
  cover property (RX_LOAD && RX_IRQ);
  cover property (TX_ABORT_REQ[2] && TX_ABORT_OK[2]);
  cover property (TX_IRQ && !SOFT_RESET);
endmodule

bind cantx_top cantx_chk chk_u (.*);

// >>> bench/cantx_node.sv
// Other nodes on the bus: deliver frames and report transmit outcomes.
module cantx_node (
  input  wire logic        clk,
  output logic             rx_done,
  output logic [31:0]      rx_ident,
  output logic             rx_ext,
  output logic [2:0]       tx_sent,
  output logic [2:0]       tx_abort_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus starts idle with scrambled identifier lines.
  initial begin
    rx_done = 1'b0;
    rx_ident = 32'hA5A5A5A5;
    rx_ext = 1'b0;
    tx_sent = 3'h0;
    tx_abort_ok = 3'h0;
  end
  // Lines are inverted after a frame so stale bits never look valid.
  task automatic rx(input logic [31:0] id, input logic ext);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_ident <= id;
    rx_ext <= ext;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_ident <= ~id;
    rx_ext <= ~ext;
  endtask
  // Outcome of a scheduled buffer: sent, or an abortable attempt.
  task automatic tx(input logic [2:0] m, input logic ab);
    @(posedge clk);
    if (ab) tx_abort_ok <= m;
    else tx_sent <= m;
    @(posedge clk);
    tx_sent <= 3'h0;
    tx_abort_ok <= 3'h0;
  endtask
endmodule

// >>> bench/cantx_top_test.sv
module cantx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] m;
    logic [31:0] c, k, id;
    logic e, a;
    logic [1:0] h;
  } cantx_row_t;
  logic        CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
  logic        SLEEP = 1'b0, RX_FULL_CLR = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [7:0]  WDATA = 8'h00, RX_ERR_CNT = 8'h5A, TX_ERR_CNT = 8'hA5;
  logic [7:0]  RDATA, d;
  logic        RX_DONE, RX_EXT, SOFT_RESET, RX_LOAD, RX_IRQ, TX_IRQ;
  logic [31:0] RX_IDENT;
  logic [2:0]  TX_SENT, TX_ABORT_OK, TX_EMPTY, TX_ABORT_REQ;
  logic [1:0]  FILTER_HIT;
  // Hit of the message now in the foreground; rejects leave it alone.
  logic [1:0]  hit_exp = 2'h0;
  int          failures = 0, tests_run = 0;
  cantx_row_t  r;
  // Mode, code, mask, identifier, extended, accepted, hit.
  cantx_row_t  rows [7] = '{
    '{2'h0, 32'h12345678, 32'h0, 32'h12345678, 1'b1, 1'b1, 2'h0},
    '{2'h0, 32'h12345678, 32'h0, 32'h12345679, 1'b1, 1'b0, 2'h0},
    '{2'h0, 32'h12345678, 32'hFF, 32'h123456AA, 1'b1, 1'b1, 2'h0},
    '{2'h0, 32'h12345678, 32'h70000, 32'h1234FFFF, 1'b0, 1'b1, 2'h0},
    '{2'h1, 32'hAAAA1234, 32'h0, 32'h12341234, 1'b1, 1'b1, 2'h1},
    '{2'h2, 32'hAABBCC12, 32'h0, 32'h12121212, 1'b1, 1'b1, 2'h3},
    '{2'h3, 32'h12345678, 32'hFFFFFFFF, 32'h12345678, 1'b1, 1'b0, 2'h0}};

  always #2 CLK = ~CLK;
  cantx_top dut_u (.*);
  cantx_node node_u (.clk(CLK), .rx_done(RX_DONE), .rx_ident(RX_IDENT),
    .rx_ext(RX_EXT), .tx_sent(TX_SENT), .tx_abort_ok(TX_ABORT_OK));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle strobes; the extra edge keeps strobes from meeting.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic end_sim;
    $display("%0d checks, %0d failures", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A hang cuts the run short well past the expected few hundred cycles.
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(4'h1); chk(d, 8'h07);
    rd(4'h6); chk(d, 8'h01);
    rd(4'h7); chk(d, 8'h00);
    rd(4'h4); chk(d, 8'h5A);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      wr(4'h6, 8'h01);
      for (int j = 0; j < 4; j++) begin
        wr(4'(8 + j), r.c[31-8*j -: 8]);
        wr(4'(12 + j), r.k[31-8*j -: 8]);
      end
      wr(4'h3, {2'h0, r.m, 4'h0});
      wr(4'h6, 8'h00);
      wr(4'h0, {7'h0, i[0]});
      node_u.rx(r.id, r.e);
      #1 chk(RX_LOAD, r.a);
      chk(RX_IRQ, r.a & i[0]);
      if (r.a) hit_exp = r.h;
      chk(FILTER_HIT, hit_exp);
      wr(4'h3, 8'h30);
      rd(4'h3); chk(d, {2'h0, r.m, 2'h0, hit_exp});
      @(posedge CLK) RX_FULL_CLR <= 1'b1;
      @(posedge CLK) RX_FULL_CLR <= 1'b0;
      #1 chk(RX_IRQ, 1'b0);
      $display("filter row %0d done", i);
    end
    rd(4'h4); chk(d, 8'h00);
    @(posedge CLK) SLEEP <= 1'b1;
    rd(4'h5); chk(d, 8'hA5);
    @(posedge CLK) SLEEP <= 1'b0;
    wr(4'h2, 8'h07); #1 chk(TX_IRQ, 1'b1);
    // Buffers count as loaded here and are not touched until empty again.
    wr(4'h1, 8'h06);
    wr(4'h1, 8'h00);
    rd(4'h1); chk(d, 8'h01);
    wr(4'h2, 8'h06); #1 chk(TX_IRQ, 1'b0);
    wr(4'h1, 8'h01);
    node_u.tx(3'h2, 1'b0);
    rd(4'h1); chk(d, 8'h02);
    wr(4'h2, 8'h46);
    wr(4'h2, 8'h06); #1 chk(TX_ABORT_REQ, 3'h4);
    node_u.tx(3'h4, 1'b1);
    #1 chk(TX_ABORT_REQ, 3'h0);
    chk(TX_IRQ, 1'b1);
    rd(4'h1); chk(d, 8'h46);
    wr(4'h1, 8'h04);
    rd(4'h1); chk(d, 8'h02);
    wr(4'h6, 8'h01);
    wr(4'h2, 8'h07);
    rd(4'h2); chk(d, 8'h00);
    rd(4'h1); chk(d, 8'h07);
    $display("transmit test done");
    // A hard reset in mid-run must bring back a flag that software cleared.
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h01);
    #1 chk(TX_EMPTY, 3'h6);
    @(posedge CLK) RSTN <= 1'b0;
    @(posedge CLK) RSTN <= 1'b1;
    #1 chk(TX_EMPTY, 3'h7);
    repeat (3) @(posedge CLK);
    rd(4'h1); chk(d, 8'h07);
    rd(4'h6); chk(d, 8'h01);
    $display("hard reset test done");
    end_sim();
  end
endmodule
